// file: pkg/csscb_map.svh
// offsets, field positions, reset values and timing of the clock config bank
// assumes a 250 MHz core clock; included by both design modules
`ifndef CSSCB_MAP_SVH
`define CSSCB_MAP_SVH
`define CSSCB_OFF_FREQ 7'h00
`define CSSCB_OFF_PROC 7'h01
`define CSSCB_OFF_BUS 7'h02
`define CSSCB_OFF_MEM 7'h03
`define CSSCB_OFF_RSV 7'h04
`define CSSCB_OFF_STOP 7'h05
`define CSSCB_OFF_WDOG 7'h06
`define CSSCB_OFF_WCTL 7'h09
`define CSSCB_B0_SPRH 7
`define CSSCB_B0_SELL 4
`define CSSCB_B0_BYP 3
`define CSSCB_B0_SELH 1
`define CSSCB_B0_SPRL 0
`define CSSCB_B0_LOCKED_WMASK 8'h81
`define CSSCB_B3_WMASK 8'h77
`define CSSCB_B5_WMASK 8'h1f
`define CSSCB_B6_SKEW 6
`define CSSCB_B6_CNT 1
`define CSSCB_B6_UNIT 0
`define CSSCB_B9_RSTEN 4
`define CSSCB_B9_FLAG 2
`define CSSCB_B9_WDEN 1
`define CSSCB_RST_B0 8'h00
`define CSSCB_RST_B1 3'h7
`define CSSCB_RST_B2 8'hff
`define CSSCB_RST_B3 8'hbf
`define CSSCB_RST_B5 8'h03
`define CSSCB_RST_B6 8'h3e
`define CSSCB_CLK_MHZ 250
`define CSSCB_SHORT_UNIT_US 150000
`define CSSCB_LONG_UNIT_US 2500000
`define CSSCB_RST_PULSE_NS 1000
`define CSSCB_SLAVE_ADDR 7'h50
`endif

// file: pkg/csscb_pkg.sv
// types shared by the clock config bank and its serial slave
// assumes csscb_map.svh on the include path
package csscb_pkg;
  typedef enum logic [3:0] {
    CSSCB_S_IDLE, CSSCB_S_ADDR, CSSCB_S_AACK, CSSCB_S_CMD, CSSCB_S_CACK,
    CSSCB_S_WDAT, CSSCB_S_WACK, CSSCB_S_RDAT, CSSCB_S_RACK, CSSCB_S_SKIP
  } csscb_slv_state_type;
  typedef struct packed {
    logic [6:0] offset;
    logic [7:0] data;
  } csscb_wr_type;
  typedef struct packed {
    logic [4:0] freq_select;
    logic [1:0] spread;
    logic [2:0] proc_run;    // proc zero, proc one, differential pair
    logic [7:0] bus_group_en; // mem six, free bus, bus six..one
    logic fixed48_en;
    logic sel_en;
    logic sel_rate;
    logic [2:0] mem_pair_en;
    logic [1:0] ref_en;      // crystal copy one, zero
    logic [1:0] skew;
  } csscb_clk_ctl_type;
endpackage

// file: logic/csscb_smbus_slave.sv
// smbus byte read/write slave: start/stop, address, command, one data byte
// assumes raw scl/sda pins; open-drain wire resolved outside from sda_oe
`timescale 1ns/1ps
`include "csscb_map.svh"
module csscb_smbus_slave #(
  parameter logic [6:0] SLAVE_ADDR = `CSSCB_SLAVE_ADDR
)
(
  input wire logic clk, // core clock
  input wire logic srst, // sync reset
  input wire logic scl_in, // raw clock pin
  input wire logic sda_in, // raw data pin
  output logic sda_oe, // pull data low
  output logic wr_valid, // one-cycle commit
  output csscb_pkg::csscb_wr_type wr, // committed byte
  output logic [6:0] rd_off, // offset last addressed
  input wire logic [7:0] rd_data // byte at rd_off
);
  import csscb_pkg::*;
  logic [2:0] scl_p, sda_p;
  csscb_slv_state_type st, next_st;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sh, next_sh;
  logic rw, next_rw, next_oe, next_wv;
  logic [6:0] next_off;
  logic scl_rise, scl_fall, start, stop;
  always_ff @(posedge clk)
  begin
    scl_p <= {scl_p[1:0], scl_in};
    sda_p <= {sda_p[1:0], sda_in};
  end
  assign scl_rise = scl_p[1] & ~scl_p[2];
  assign scl_fall = ~scl_p[1] & scl_p[2];
  assign start = scl_p[1] & scl_p[2] & sda_p[2] & ~sda_p[1];
  assign stop = scl_p[1] & scl_p[2] & ~sda_p[2] & sda_p[1];
  always_comb
  begin
    next_st = st;
    next_cnt = cnt;
    next_sh = sh;
    next_rw = rw;
    next_oe = sda_oe;
    next_off = rd_off;
    next_wv = 1'b0;
    if (start)
    begin
      next_st = CSSCB_S_ADDR;
      next_cnt = '0;
      next_oe = 1'b0;
    end
    else if (stop)
    begin
      next_st = CSSCB_S_IDLE;
      next_oe = 1'b0;
    end
    else if (scl_rise && (st == CSSCB_S_ADDR || st == CSSCB_S_CMD || st == CSSCB_S_WDAT))
    begin
      // msb arrives first
      next_sh = {sh[6:0], sda_p[1]};
      next_cnt = cnt + 4'h1;
    end
    else if (scl_fall)
    begin
      unique case (st)
        CSSCB_S_ADDR:
          if (cnt == 4'h8)
          begin
            next_st = (sh[7:1] == SLAVE_ADDR) ? CSSCB_S_AACK : CSSCB_S_SKIP;
            next_oe = (sh[7:1] == SLAVE_ADDR);
            next_rw = sh[0];
          end
        CSSCB_S_AACK:
        begin
          next_cnt = '0;
          next_st = rw ? CSSCB_S_RDAT : CSSCB_S_CMD;
          next_sh = rd_data;
          next_oe = rw & ~rd_data[7];
        end
        CSSCB_S_CMD:
          if (cnt == 4'h8)
          begin
            // only byte operations are answered; block mode is refused
            next_st = sh[7] ? CSSCB_S_CACK : CSSCB_S_SKIP;
            next_oe = sh[7];
            next_off = sh[7] ? sh[6:0] : rd_off;
          end
        CSSCB_S_CACK:
        begin
          next_oe = 1'b0;
          next_cnt = '0;
          next_st = CSSCB_S_WDAT;
        end
        CSSCB_S_WDAT:
          if (cnt == 4'h8)
          begin
            next_st = CSSCB_S_WACK;
            next_oe = 1'b1;
          end
        CSSCB_S_WACK:
        begin
          // commit only once the acknowledge clock has completed
          next_oe = 1'b0;
          next_wv = 1'b1;
          next_st = CSSCB_S_SKIP;
        end
        CSSCB_S_RDAT:
          if (cnt == 4'h7)
          begin
            next_oe = 1'b0;
            next_st = CSSCB_S_RACK;
          end
          else
          begin
            next_sh = {sh[6:0], 1'b0};
            next_oe = ~sh[6];
            next_cnt = cnt + 4'h1;
          end
        CSSCB_S_RACK: next_st = CSSCB_S_SKIP;
        CSSCB_S_IDLE, CSSCB_S_SKIP: next_st = st;
      endcase
    end
  end
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st <= CSSCB_S_IDLE;
      cnt <= '0;
      sh <= '0;
      rw <= 1'b0;
      sda_oe <= 1'b0;
      rd_off <= '0;
      wr_valid <= 1'b0;
      wr <= '0;
    end
    else
    begin
      st <= next_st;
      cnt <= next_cnt;
      sh <= next_sh;
      rw <= next_rw;
      sda_oe <= next_oe;
      rd_off <= next_off;
      wr_valid <= next_wv;
      wr <= next_wv ? {rd_off, sh} : wr;
    end
  end
endmodule

// file: logic/csscb_top.sv
// configuration bank of the clock synthesizer: bytes 0-6, watchdog control byte 9
// assumes smbus pins and straps are asynchronous; clock outputs are levels
`timescale 1ns/1ps
`include "csscb_map.svh"
module csscb_top #(
  parameter int unsigned SHORT_UNIT_CYCLES = `CSSCB_SHORT_UNIT_US * `CSSCB_CLK_MHZ,
  parameter int unsigned LONG_UNIT_CYCLES = `CSSCB_LONG_UNIT_US * `CSSCB_CLK_MHZ,
  parameter logic [6:0] SLAVE_ADDR = `CSSCB_SLAVE_ADDR
)
(
  input wire logic clk, // 250 MHz core clock
  input wire logic srst, // sync reset, active high
  input wire logic scl_in, // smbus clock pin
  input wire logic sda_in, // smbus data pin level
  output logic sda_out, // value driven when enabled
  output logic sda_oe, // high pulls data low
  input wire logic [4:0] strap_frequency_inputs, // power-on straps
  input wire logic proc_stop_n, // processor stop, low active
  output csscb_pkg::csscb_clk_ctl_type clk_ctl, // clock controls
  output logic sys_reset, // system reset pulse
  output logic timeout_occurred_flag, // watchdog expired
  output logic recovery_lock // locked in recovery frequency
);
  import csscb_pkg::*;
  localparam int unsigned PULSE_CYCLES = `CSSCB_RST_PULSE_NS * `CSSCB_CLK_MHZ / 1000;
  localparam logic [31:0] SHORT_LOAD = 32'(SHORT_UNIT_CYCLES - 1);
  localparam logic [31:0] LONG_LOAD = 32'(LONG_UNIT_CYCLES - 1);
  localparam logic [7:0] PULSE_LOAD = 8'(PULSE_CYCLES);

  logic wr_valid;
  csscb_wr_type wr;
  logic [6:0] rd_off;
  logic [7:0] rd_data;

  csscb_smbus_slave #(
    .SLAVE_ADDR(SLAVE_ADDR)
  ) i_csscb_smbus_slave (
    .clk(clk),
    .srst(srst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe(sda_oe),
    .wr_valid(wr_valid),
    .wr(wr),
    .rd_off(rd_off),
    .rd_data(rd_data)
  );

  // pin synchronisers; not reset, reset must be held two edges
  logic [4:0] strap_s1, strap_s2;
  logic [1:0] stop_s;
  always_ff @(posedge clk)
  begin
    strap_s1 <= strap_frequency_inputs;
    strap_s2 <= strap_s1;
    stop_s <= {stop_s[0], proc_stop_n};
    sda_out <= 1'b0; // open drain: only ever pulls low
  end

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] dat,
                                       input logic [7:0] msk);
    merge = (dat & msk) | (old & ~msk);
  endfunction

  // configuration bytes
  logic [7:0] b0, b2, b3, b5, b6, next_b0, next_b2, next_b3, next_b5, next_b6;
  logic [2:0] b1, next_b1;
  logic [4:0] strap_q, next_strap_q;
  logic taken, next_taken, rst_en, next_rst_en, guard_timer_enable, next_guard_timer_enable;
  logic wr0, wr1, wr2, wr3, wr5, wr6, wr9;

  assign wr0 = wr_valid && wr.offset == `CSSCB_OFF_FREQ;
  assign wr1 = wr_valid && wr.offset == `CSSCB_OFF_PROC;
  assign wr2 = wr_valid && wr.offset == `CSSCB_OFF_BUS;
  assign wr3 = wr_valid && wr.offset == `CSSCB_OFF_MEM;
  assign wr5 = wr_valid && wr.offset == `CSSCB_OFF_STOP;
  assign wr6 = wr_valid && wr.offset == `CSSCB_OFF_WDOG;
  assign wr9 = wr_valid && wr.offset == `CSSCB_OFF_WCTL;

  always_comb
  begin
    // straps caught on the first edge after reset release
    next_taken = 1'b1;
    next_strap_q = taken ? strap_q : strap_s2;
    // locked: select code and bypass hold, spread still writable
    next_b0 = wr0 ? merge(b0, wr.data, recovery_lock ? `CSSCB_B0_LOCKED_WMASK : 8'hff) : b0;
    next_b1 = wr1 ? wr.data[2:0] : b1;
    next_b2 = wr2 ? wr.data : b2;
    next_b3 = wr3 ? merge(b3, wr.data, `CSSCB_B3_WMASK) : b3;
    next_b5 = wr5 ? merge(b5, wr.data, `CSSCB_B5_WMASK) : b5;
    next_b6 = wr6 ? wr.data : b6;
    next_rst_en = wr9 ? wr.data[`CSSCB_B9_RSTEN] : rst_en;
    next_guard_timer_enable = wr9 ? wr.data[`CSSCB_B9_WDEN] : guard_timer_enable;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      taken <= 1'b0;
      strap_q <= '0;
      b0 <= `CSSCB_RST_B0;
      b1 <= `CSSCB_RST_B1;
      b2 <= `CSSCB_RST_B2;
      b3 <= `CSSCB_RST_B3;
      b5 <= `CSSCB_RST_B5;
      b6 <= `CSSCB_RST_B6;
      rst_en <= 1'b0;
      guard_timer_enable <= 1'b0;
    end
    else
    begin
      taken <= next_taken;
      strap_q <= next_strap_q;
      b0 <= next_b0;
      b1 <= next_b1;
      b2 <= next_b2;
      b3 <= next_b3;
      b5 <= next_b5;
      b6 <= next_b6;
      rst_en <= next_rst_en;
      guard_timer_enable <= next_guard_timer_enable;
    end
  end

  // read mux; unmapped offsets return zero
  always_comb
  begin
    unique case (rd_off)
      `CSSCB_OFF_FREQ: rd_data = b0;
      `CSSCB_OFF_PROC: rd_data = {strap_q, b1};
      `CSSCB_OFF_BUS: rd_data = b2;
      `CSSCB_OFF_MEM: rd_data = b3;
      `CSSCB_OFF_STOP: rd_data = b5;
      `CSSCB_OFF_WDOG: rd_data = b6;
      `CSSCB_OFF_WCTL:
        rd_data = {3'h0, rst_en, 1'b0, timeout_occurred_flag, guard_timer_enable, 1'b0};
      default: rd_data = 8'h00;
    endcase
  end

  // frequency selection and clock controls
  logic [4:0] sel_code, next_freq;
  csscb_clk_ctl_type next_ctl;
  logic freq_change;
  assign sel_code = {b0[`CSSCB_B0_SELH +: 2], b0[`CSSCB_B0_SELL +: 3]};

  always_comb
  begin
    // recovery reloads the hardware-selected frequency
    if (recovery_lock || !b0[`CSSCB_B0_BYP])
      next_freq = strap_q;
    else
      next_freq = sel_code;
    next_ctl.freq_select = next_freq;
    next_ctl.spread = {b0[`CSSCB_B0_SPRH], b0[`CSSCB_B0_SPRL]};
    next_ctl.proc_run = b1 & ({b5[3], b5[4], b5[2]} | {3{stop_s[1]}});
    next_ctl.bus_group_en = b2;
    next_ctl.fixed48_en = b3[5];
    next_ctl.sel_en = b3[4];
    next_ctl.sel_rate = b3[6];
    next_ctl.mem_pair_en = b3[2:0];
    next_ctl.ref_en = b5[1:0];
    next_ctl.skew = b6[`CSSCB_B6_SKEW +: 2];
  end
  assign freq_change = taken && (next_freq != clk_ctl.freq_select);

  // watchdog
  logic running, next_running, next_lock, next_flag, expire;
  logic [31:0] unit_cnt, next_unit_cnt;
  logic [4:0] left, next_left;
  logic [7:0] pulse, next_pulse;
  logic [31:0] unit_load;

  assign unit_load = b6[`CSSCB_B6_UNIT] ? LONG_LOAD : SHORT_LOAD;
  assign expire = running && unit_cnt == 32'h0 && left == 5'h0;

  always_comb
  begin
    next_running = running;
    next_unit_cnt = unit_cnt;
    next_left = left;
    next_lock = recovery_lock;
    next_pulse = (pulse != 8'h0) ? pulse - 8'h1 : pulse;
    if (!guard_timer_enable)
    begin
      next_running = 1'b0;
      next_lock = 1'b0;
      next_unit_cnt = unit_load;
      next_left = b6[`CSSCB_B6_CNT +: 5];
    end
    else if (expire)
    begin
      next_running = 1'b0;
      next_lock = 1'b1;
      next_pulse = rst_en ? PULSE_LOAD : next_pulse;
    end
    else if (running)
    begin
      if (unit_cnt != 32'h0)
        next_unit_cnt = unit_cnt - 32'h1;
      else
      begin
        // count N expires after N+1 whole units
        next_left = left - 5'h1;
        next_unit_cnt = unit_load;
      end
    end
    else if (freq_change && !recovery_lock)
    begin
      next_running = 1'b1;
      next_unit_cnt = unit_load;
      next_left = b6[`CSSCB_B6_CNT +: 5];
    end
    // a clear in the expiry cycle loses to the new event
    next_flag = expire | (timeout_occurred_flag & ~(wr9 & wr.data[`CSSCB_B9_FLAG]));
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      running <= 1'b0;
      recovery_lock <= 1'b0;
      timeout_occurred_flag <= 1'b0;
      unit_cnt <= '0;
      left <= '0;
      pulse <= '0;
      sys_reset <= 1'b0;
      clk_ctl <= '0;
    end
    else
    begin
      running <= next_running;
      recovery_lock <= next_lock;
      timeout_occurred_flag <= next_flag;
      unit_cnt <= next_unit_cnt;
      left <= next_left;
      pulse <= next_pulse;
      sys_reset <= next_pulse != 8'h0;
      clk_ctl <= next_ctl;
    end
  end

  // checks
  property p_bypass_sel;
    @(posedge clk) disable iff (srst)
    (taken && !recovery_lock && b0[`CSSCB_B0_BYP]) |=> clk_ctl.freq_select == $past(sel_code);
  endproperty
  a_bypass_sel: assert property (p_bypass_sel)
  else $error("register select code not applied");

  property p_strap_sel;
    @(posedge clk) disable iff (srst)
    (taken && !b0[`CSSCB_B0_BYP]) |=> clk_ctl.freq_select == $past(strap_q);
  endproperty
  a_strap_sel: assert property (p_strap_sel)
  else $error("strap frequency not applied");

  property p_strap_read;
    @(posedge clk) disable iff (srst)
    (rd_off == `CSSCB_OFF_PROC) |-> rd_data[7:3] == strap_q && rd_data[2:0] == b1;
  endproperty
  a_strap_read: assert property (p_strap_read)
  else $error("byte 1 readback wrong");

  property p_expire;
    @(posedge clk) disable iff (srst)
    (expire && guard_timer_enable) |=> timeout_occurred_flag && recovery_lock && !running
      ##1 (sys_reset == $past(rst_en, 2));
  endproperty
  a_expire: assert property (p_expire)
  else $error("expiry did not flag, lock or pulse");

  property p_flag_clear;
    @(posedge clk) disable iff (srst)
    (wr9 && wr.data[`CSSCB_B9_FLAG] && !expire) |=> !timeout_occurred_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
  else $error("timeout flag not cleared");

  property p_unlock;
    @(posedge clk) disable iff (srst)
    !guard_timer_enable |=> !recovery_lock && !running;
  endproperty
  a_unlock: assert property (p_unlock)
  else $error("cleared enable did not stop and unlock");

  property p_lock_hold;
    @(posedge clk) disable iff (srst)
    (recovery_lock && wr0) |=> $stable(b0[6:1]) && clk_ctl.freq_select == $past(strap_q, 2);
  endproperty
  a_lock_hold: assert property (p_lock_hold)
  else $error("frequency changed while locked");

  property p_no_partial;
    @(posedge clk) disable iff (srst)
    !wr_valid |=> $stable(b2) && $stable(b6) && $stable(b0);
  endproperty
  a_no_partial: assert property (p_no_partial)
  else $error("byte changed without a completed write");

  property p_stop_mask;
    @(posedge clk) disable iff (srst)
    (!stop_s[1] && !b5[4]) |=> !clk_ctl.proc_run[1];
  endproperty
  a_stop_mask: assert property (p_stop_mask)
  else $error("unmasked processor clock kept running");

  property p_unit_load;
    @(posedge clk) disable iff (srst)
    (freq_change && guard_timer_enable && !running && !recovery_lock && !expire)
      |=> running && left == $past(b6[5:1]) && unit_cnt == $past(unit_load);
  endproperty
  a_unit_load: assert property (p_unit_load)
  else $error("watchdog not loaded on frequency change");
endmodule

// file: tb/csscb_host_model.sv
// smbus host model: byte write, byte read, and a write cut short by a stop
// assumes the bench resolves sda as an open-drain wire with a pull-up
`timescale 1ns/1ps
module csscb_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
)
(
  input wire logic clk, // core clock
  input wire logic sda_line, // resolved data wire
  output logic scl, // bus clock, host only
  output logic sda_low // high pulls data low
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // slot starts and ends with scl low; sampled mid-high, away from clock edges
  task automatic put_bit(input logic b, output logic r);
    tick(6);
    sda_low <= ~b;
    tick(6);
    scl <= 1'b1;
    tick(5);
    @(negedge clk);
    r = sda_line;
    tick(4);
    scl <= 1'b0;
  endtask
  // also serves as repeated start, since scl may still be low
  task automatic start_cond();
    tick(6);
    sda_low <= 1'b0;
    tick(6);
    scl <= 1'b1;
    tick(6);
    sda_low <= 1'b1;
    tick(6);
    scl <= 1'b0;
  endtask
  task automatic stop_cond();
    tick(6);
    sda_low <= 1'b1;
    tick(6);
    scl <= 1'b1;
    tick(6);
    sda_low <= 1'b0;
    tick(6);
  endtask
  // a one is a release, so 8'hff then a one reads a byte and answers not-ack
  task automatic put_byte(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      put_bit(d[i], r);
      q[i] = r;
    end
    put_bit(1'b1, r);
    ack = ~r;
  endtask
  task automatic wr_byte(input logic [7:0] cmd, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2;
    start_cond();
    put_byte({DEV_ADDR, 1'b0}, q, a0);
    put_byte(cmd, q, a1);
    put_byte(d, q, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
  task automatic rd_byte(input logic [7:0] cmd, output logic [7:0] q, output logic ok);
    logic a0, a1, a2, a3;
    start_cond();
    put_byte({DEV_ADDR, 1'b0}, q, a0);
    put_byte(cmd, q, a1);
    start_cond();
    put_byte({DEV_ADDR, 1'b1}, q, a2);
    put_byte(8'hff, q, a3);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
  task automatic cut_write(input logic [7:0] cmd, input logic [7:0] d);
    logic [7:0] q;
    logic a, r;
    start_cond();
    put_byte({DEV_ADDR, 1'b0}, q, a);
    put_byte(cmd, q, a);
    for (int i = 7; i >= 4; i--)
      put_bit(d[i], r);
    stop_cond();
  endtask
endmodule

// file: tb/csscb_top_tb.sv
// self-checking bench for the clock config bank through its smbus pins
// assumes csscb_map.svh on the include path; units shortened to 20 and 50 cycles
`timescale 1ns/1ps
module csscb_top_tb;
  import csscb_pkg::*;
  localparam logic [4:0] STRAPS = 5'h13;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic proc_stop_n = 1'b1;
  logic [4:0] straps = STRAPS;
  logic scl, sda_low, sda_out, sda_oe, sys_reset, flag, lock;
  logic [4:0] last_freq;
  wire logic sda_line;
  csscb_clk_ctl_type clk_ctl, ctl_exp;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  int since_change = 0;
  int rst_len = 0;
  int rst_width = 0;
  int rst_rises = 0;
  always #2 clk = ~clk;
  assign sda_line = ~(sda_low | (sda_oe & ~sda_out));
  csscb_top #(.SHORT_UNIT_CYCLES(20), .LONG_UNIT_CYCLES(50), .SLAVE_ADDR(7'h50)) i_csscb_top (
    .clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .strap_frequency_inputs(straps), .proc_stop_n(proc_stop_n),
    .clk_ctl(clk_ctl), .sys_reset(sys_reset), .timeout_occurred_flag(flag),
    .recovery_lock(lock));
  csscb_host_model #(.DEV_ADDR(7'h50)) i_csscb_host_model (
    .clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  // cycle ceiling well above the roughly 30k cycles the sequence needs
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    last_freq <= clk_ctl.freq_select;
    since_change <= (clk_ctl.freq_select !== last_freq) ? 0 : since_change + 1;
    rst_len <= (sys_reset === 1'b1) ? rst_len + 1 : 0;
    if (sys_reset !== 1'b1 && rst_len != 0)
      rst_width <= rst_len;
    if (sys_reset === 1'b1 && rst_len == 0)
      rst_rises <= rst_rises + 1;
    if (cycles == 90000)
    begin
      err_total++;
      test_done();
    end
  end
  task automatic bad(input string what);
    err_total++;
    $display("wrong value at %0t: %s", $time, what);
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
      bad($sformatf("%s got %h expected %h", what, got, exp));
  endtask
  task automatic chk_ctl();
    samples_checked++;
    if (clk_ctl !== ctl_exp)
      bad($sformatf("clock controls got %h expected %h", clk_ctl, ctl_exp));
  endtask
  task automatic chk_range(input int got, input int lo, input int hi, input string what);
    samples_checked++;
    if (got < lo || got > hi)
      bad($sformatf("%s got %0d expected %0d..%0d", what, got, lo, hi));
  endtask
  task automatic wr(input logic [6:0] off, input logic [7:0] d);
    logic ok;
    i_csscb_host_model.wr_byte({1'b1, off}, d, ok);
    chk_byte({7'h0, ok}, 8'h01, "write ack");
  endtask
  task automatic rd(input logic [6:0] off, input logic [7:0] exp);
    logic [7:0] q;
    logic ok;
    i_csscb_host_model.rd_byte({1'b1, off}, q, ok);
    chk_byte(q, exp, "read byte");
  endtask
  task automatic wait_flag();
    int n;
    n = 0;
    while (flag !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic t_reset();
    logic [7:0] exp [0:7];
    exp = '{8'h00, {STRAPS, 3'h7}, 8'hff, 8'hbf, 8'h00, 8'h03, 8'h3e, 8'h00};
    for (int i = 0; i < 8; i++)
      rd((i < 7) ? 7'(i) : 7'h09, exp[i]);
    chk_ctl();
  endtask
  task automatic t_rw();
    wr(7'h01, 8'hfa);
    rd(7'h01, {STRAPS, 3'h2});
    wr(7'h02, 8'h5a);
    wr(7'h03, 8'h45);
    rd(7'h03, 8'hcd);
    wr(7'h05, 8'h10);
    rd(7'h05, 8'h10);
    ctl_exp.proc_run = 3'h2;
    ctl_exp.bus_group_en = 8'h5a;
    {ctl_exp.sel_rate, ctl_exp.fixed48_en, ctl_exp.sel_en} = 3'b100;
    ctl_exp.mem_pair_en = 3'h5;
    ctl_exp.ref_en = 2'h0;
    chk_ctl();
    wr(7'h01, 8'h07);
    proc_stop_n <= 1'b0;
    repeat (8) @(posedge clk);
    ctl_exp.proc_run = 3'h2;
    chk_ctl();
    wr(7'h05, 8'h0c);
    ctl_exp.proc_run = 3'h5;
    chk_ctl();
    proc_stop_n <= 1'b1;
    repeat (8) @(posedge clk);
    ctl_exp.proc_run = 3'h7;
    chk_ctl();
  endtask
  task automatic t_freq();
    for (int s = 0; s < 4; s++)
    begin
      wr(7'h00, {s[1], 6'h00, s[0]});
      ctl_exp.spread = 2'(s);
      chk_ctl();
    end
    wr(7'h00, 8'h5a);
    {ctl_exp.freq_select, ctl_exp.spread} = {5'h0d, 2'h0};
    chk_ctl();
    wr(7'h00, 8'hac);
    {ctl_exp.freq_select, ctl_exp.spread} = {5'h12, 2'h2};
    chk_ctl();
    wr(7'h00, 8'h00);
    {ctl_exp.freq_select, ctl_exp.spread} = {STRAPS, 2'h0};
    wr(7'h06, 8'h7e);
    ctl_exp.skew = 2'h1;
    chk_ctl();
  endtask
  task automatic t_misc();
    logic ok;
    wr(7'h07, 8'h60);
    rd(7'h07, 8'h00);
    rd(7'h03, 8'hcd);
    i_csscb_host_model.wr_byte(8'h02, 8'h00, ok);
    chk_byte({7'h0, ok}, 8'h00, "block refused");
    i_csscb_host_model.cut_write(8'h82, 8'h00);
    rd(7'h02, 8'h5a);
    chk_ctl();
  endtask
  task automatic t_wdog();
    int rises;
    wr(7'h06, 8'hc4);
    wr(7'h09, 8'h12);
    wr(7'h00, 8'h18);
    wait_flag();
    chk_range(since_change, 54, 63, "short expiry");
    repeat (270) @(posedge clk);
    chk_range(rst_width, 250, 250, "reset pulse");
    chk_byte({6'h0, flag, lock}, 8'h03, "flag and lock");
    ctl_exp.skew = 2'h3;
    chk_ctl();
    rd(7'h09, 8'h16);
    wr(7'h00, 8'h99);
    ctl_exp.spread = 2'h3;
    chk_ctl();
    wr(7'h09, 8'h16);
    chk_byte({6'h0, flag, lock}, 8'h01, "flag cleared");
    rd(7'h09, 8'h12);
    wr(7'h09, 8'h00);
    ctl_exp.freq_select = 5'h01;
    chk_ctl();
    repeat (100) @(posedge clk);
    chk_byte({6'h0, flag, lock}, 8'h00, "stopped and unlocked");
    wr(7'h06, 8'h01);
    wr(7'h09, 8'h02);
    rises = rst_rises;
    wr(7'h00, 8'h28);
    wait_flag();
    chk_range(since_change, 44, 53, "long expiry");
    repeat (20) @(posedge clk);
    chk_range(rst_rises, rises, rises, "no reset when disabled");
  endtask
  task automatic test_done();
    $display("mismatches %0d, comparisons %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    ctl_exp = '{freq_select: STRAPS, spread: 2'h0, proc_run: 3'h7, bus_group_en: 8'hff,
      fixed48_en: 1'b1, sel_en: 1'b1, sel_rate: 1'b0, mem_pair_en: 3'h7, ref_en: 2'h3,
      skew: 2'h0};
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_rw();
    t_freq();
    t_misc();
    t_wdog();
    test_done();
  end
endmodule
